// File: spi_eeprom_fe_pkg.sv
// constants, types and message layouts for the serial memory front end
package spi_eeprom_fe_pkg;

   // ==========================================================
   // timing
   localparam int T_WRITE_CYCLE_MS = 5;
   localparam int CLK_FREQ_KHZ = 250_000;
   // longest time; ms times kHz gives a whole 1250000 clocks, no rounding
   localparam int WRITE_CYCLE_CLKS = T_WRITE_CYCLE_MS * CLK_FREQ_KHZ;

   // ==========================================================
   // serial framing
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] LAST_BIT_IDX = 3'h7;
   localparam logic [3:0] OPC_UPPER_VAL = 4'h0;

   // ==========================================================
   // status byte
   localparam logic [7:0] STATUS_RST_VAL = 8'h00;
   localparam logic [7:0] STATUS_BUSY_VAL = 8'hff;
   localparam int SR_BUSY_POS = 0;
   localparam int SR_WEL_POS = 1;
   localparam int SR_BP_LOW_POS = 2;
   localparam int SR_BP_HIGH_POS = 3;
   localparam int SR_PROTECT_PIN_ENABLE_BIT_POS = 7;

   // ==========================================================
   // opcode low three bits (bit 3 is don't care)
   typedef enum logic [2:0] {
      write_status_cmd = 3'h1,
      write_array_cmd = 3'h2,
      read_array_cmd = 3'h3,
      clear_write_latch_cmd = 3'h4,
      read_status_cmd = 3'h5,
      set_write_latch_cmd = 3'h6
   } cmd_t;

   // link sequence state, gray along opcode -> body -> refuse
   typedef enum logic [1:0] {
      ST_OPCODE = 2'h0,
      ST_BODY = 2'h1,
      ST_REFUSE = 2'h3
   } link_state_t;

   typedef struct packed {
      logic protect_pin_enable_bit;
      logic [2:0] rsvd;
      logic block_protect_high;
      logic block_protect_low;
      logic write_enable;
      logic busy;
   } status_t;

   // command handed from the link side to the system side
   typedef struct packed {
      cmd_t code;
      logic [7:0] data;
   } cmd_msg_t;

endpackage : spi_eeprom_fe_pkg

// File: spi_eeprom_serial_front_end.sv
// slave serial front end: opcode decode, hold, status register and write protect
// ==========================================================
// Functional notes
// - slave only; serial clock is an input, master makes every edge.
// - all bytes shift most significant bit first, both directions.
// - first byte after select is the opcode.
// - invalid opcode: ignore input, output high-z until next select.
// - deselected: input ignored, output high impedance.
// - paused: sequence state kept, output high-z, input ignored.
// - after hold release, sequence continues where it stopped.
// - write-protect high allows normal reads and writes.
// - write-protect low with pin-enable bit set refuses status writes.
// - write-protect falling while selected aborts pending status write.
// - started internal status write ignores write-protect.
// - pin-enable bit zero makes write-protect pin ignored.
// - six valid opcodes 0000x110/100/101/001/011/010; others invalid.
// - status bits: busy 0, write enable 1, block protect 3:2, pin-enable 7.
// - pin-enable bit cannot be cleared while hardware protection holds.
module spi_eeprom_serial_front_end
   import spi_eeprom_fe_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLE_CLKS
) (
   // system clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // serial link, clocked by the master
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   // status view
   output logic [7:0] o_status
);

   localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(WRITE_CYCLES - 1);

   // ==========================================================
   // state types
   typedef struct packed {
      link_state_t st;
      logic [2:0] bit_cnt;
      logic [7:0] rx_sh;
      logic [7:0] tx;
      logic cmd_done;
      cmd_msg_t msg;
      logic [7:0] stat_s1;
      logic [7:0] stat_s2;
      logic [7:0] stat_s3;
      logic [7:0] stat_ok;
   } link_t;

   typedef struct packed {
      logic so;
      logic oe;
   } drive_t;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic wp_s1;
      logic wp_s2;
      logic wp_d;
      logic cmd_s1;
      logic cmd_s2;
      logic cmd_d;
      status_t stat;
      logic pend;
      logic [7:0] wr_data;
      logic [TIMER_W-1:0] timer;
      logic [7:0] stat_out;
   } sys_t;

   localparam link_t LINK_RST = '{
      st: ST_OPCODE,
      bit_cnt: 3'h0,
      rx_sh: 8'h00,
      tx: 8'h00,
      cmd_done: 1'b0,
      msg: '{code: write_status_cmd, data: 8'h00},
      stat_s1: STATUS_RST_VAL,
      stat_s2: STATUS_RST_VAL,
      stat_s3: STATUS_RST_VAL,
      stat_ok: STATUS_RST_VAL
   };

   localparam sys_t SYS_RST = '{
      cs_s1: 1'b1,
      cs_s2: 1'b1,
      wp_s1: 1'b1,
      wp_s2: 1'b1,
      wp_d: 1'b1,
      cmd_s1: 1'b0,
      cmd_s2: 1'b0,
      cmd_d: 1'b0,
      stat: status_t'(STATUS_RST_VAL),
      pend: 1'b0,
      wr_data: 8'h00,
      timer: '0,
      stat_out: STATUS_RST_VAL
   };

   link_t lk_ff;
   link_t nxt_lk;
   drive_t drv_ff;
   drive_t nxt_drv;
   sys_t sy_ff;
   sys_t nxt_sy;

   // limitation: select must stay low a few system clocks after the last edge
   // deselect clears the whole frame asynchronously
   logic link_rst;
   // a pause also silences the output stage at once
   logic drive_rst;
   assign link_rst = i_sys_rst | i_cs_n;
   assign drive_rst = link_rst | ~i_hold_n;

   function automatic logic opcode_ok(input logic [7:0] op);
      logic ok;
      ok = 1'b0;
      if (op[7:4] == OPC_UPPER_VAL) begin
         unique case (op[2:0])
            3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6: ok = 1'b1;
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction : opcode_ok

   // ==========================================================
   // link side, rising edge of the master clock
   always_comb begin
      logic [7:0] rx_next;
      logic byte_end;
      rx_next = 8'h00;
      byte_end = 1'b0;
      nxt_lk = lk_ff;
      // level sync of the status byte into the link domain
      nxt_lk.stat_s1 = sy_ff.stat_out;
      nxt_lk.stat_s2 = lk_ff.stat_s1;
      nxt_lk.stat_s3 = lk_ff.stat_s2;
      // multi-bit word: keep it only once two samples agree, never a torn one
      if (lk_ff.stat_s2 == lk_ff.stat_s3) begin
         nxt_lk.stat_ok = lk_ff.stat_s3;
      end
      // msb first: new bit enters at the bottom
      rx_next = {lk_ff.rx_sh[6:0], i_si};
      byte_end = (lk_ff.bit_cnt == LAST_BIT_IDX);
      // hold freezes shift, count and sequence state (status sync keeps running); refuse shifts nothing
      if (i_hold_n && lk_ff.st != ST_REFUSE) begin
         // input sampled here on the rising edge
         nxt_lk.rx_sh = rx_next;
         nxt_lk.bit_cnt = lk_ff.bit_cnt + 3'h1;
         if (byte_end) begin
            unique case (lk_ff.st)
               ST_OPCODE: begin
                  if (opcode_ok(rx_next)) begin
                     nxt_lk.st = ST_BODY;
                     nxt_lk.msg.code = cmd_t'(rx_next[2:0]);
                     nxt_lk.tx = lk_ff.stat_ok;
                     if (rx_next[2:0] == set_write_latch_cmd ||
                         rx_next[2:0] == clear_write_latch_cmd) begin
                        nxt_lk.cmd_done = 1'b1;
                     end
                  end else begin
                     // invalid opcode locks out until reselect
                     nxt_lk.st = ST_REFUSE;
                  end
               end
               ST_BODY: begin
                  // status reads repeat the byte while clocks continue
                  nxt_lk.tx = lk_ff.stat_ok;
                  if (lk_ff.msg.code == write_status_cmd && !lk_ff.cmd_done) begin
                     nxt_lk.cmd_done = 1'b1;
                     nxt_lk.msg.data = rx_next;
                  end
               end
               ST_REFUSE: begin
                  nxt_lk.st = ST_REFUSE;
               end
               // unused code: lock out until the next select
               default: nxt_lk.st = ST_REFUSE;
            endcase
         end
      end
   end

   // the only clock of this stage is the master's serial clock
   always_ff @(posedge i_sck or posedge link_rst) begin
      if (link_rst) begin
         lk_ff <= LINK_RST;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // ==========================================================
   // output stage, falling edge of the master clock
   always_comb begin
      nxt_drv = drv_ff;
      // only a valid status read ever drives
      nxt_drv.oe = (lk_ff.st == ST_BODY) && (lk_ff.msg.code == read_status_cmd);
      // msb first, launched after the falling edge
      nxt_drv.so = nxt_drv.oe & lk_ff.tx[~lk_ff.bit_cnt];
   end

   // hold low forces high impedance without the clock
   always_ff @(negedge i_sck or posedge drive_rst) begin
      if (drive_rst) begin
         drv_ff <= '0;
      end else begin
         drv_ff <= nxt_drv;
      end
   end

   assign o_so = drv_ff.so;
   assign o_so_oe = drv_ff.oe;

   // ==========================================================
   // system side: status register and write cycle
   always_comb begin
      logic take;
      logic hw_prot;
      logic wp_fall;
      take = 1'b0;
      hw_prot = 1'b0;
      wp_fall = 1'b0;
      nxt_sy = sy_ff;
      nxt_sy.cs_s1 = i_cs_n;
      nxt_sy.cs_s2 = sy_ff.cs_s1;
      nxt_sy.wp_s1 = i_wp_n;
      nxt_sy.wp_s2 = sy_ff.wp_s1;
      nxt_sy.wp_d = sy_ff.wp_s2;
      // command level stays up until deselect, so the message is stable
      nxt_sy.cmd_s1 = lk_ff.cmd_done;
      nxt_sy.cmd_s2 = sy_ff.cmd_s1;
      nxt_sy.cmd_d = sy_ff.cmd_s2;
      take = sy_ff.cmd_s2 & ~sy_ff.cmd_d;
      // pin only matters with the enable bit set
      hw_prot = sy_ff.stat.protect_pin_enable_bit & ~sy_ff.wp_s2;
      wp_fall = sy_ff.wp_d & ~sy_ff.wp_s2;

      // commands taken while a write cycle runs are dropped, not held
      if (take && !sy_ff.stat.busy) begin
         unique case (lk_ff.msg.code)
            set_write_latch_cmd: nxt_sy.stat.write_enable = 1'b1;
            clear_write_latch_cmd: nxt_sy.stat.write_enable = 1'b0;
            write_status_cmd: begin
               // hardware protection refuses the status write
               if (sy_ff.stat.write_enable && !hw_prot) begin
                  nxt_sy.pend = 1'b1;
                  nxt_sy.wr_data = lk_ff.msg.data;
               end
            end
            default: nxt_sy.pend = sy_ff.pend;
         endcase
      end

      // falling pin while still selected aborts the pending write
      if (sy_ff.pend && sy_ff.stat.protect_pin_enable_bit && wp_fall && !sy_ff.cs_s2) begin
         nxt_sy.pend = 1'b0;
      end else if (sy_ff.pend && sy_ff.cs_s2) begin
         // deselect launches the self-timed cycle
         nxt_sy.pend = 1'b0;
         nxt_sy.stat.busy = 1'b1;
         nxt_sy.timer = TIMER_LOAD;
      end

      // once running, the pin is no longer consulted
      if (sy_ff.stat.busy) begin
         if (sy_ff.timer == '0) begin
            nxt_sy.stat.busy = 1'b0;
            nxt_sy.stat.write_enable = 1'b0;
            nxt_sy.stat.protect_pin_enable_bit = sy_ff.wr_data[SR_PROTECT_PIN_ENABLE_BIT_POS];
            nxt_sy.stat.block_protect_high = sy_ff.wr_data[SR_BP_HIGH_POS];
            nxt_sy.stat.block_protect_low = sy_ff.wr_data[SR_BP_LOW_POS];
         end else begin
            nxt_sy.timer = sy_ff.timer - TIMER_W'(1);
         end
      end

      // status layout; all ones while the write runs
      nxt_sy.stat.rsvd = 3'h0;
      nxt_sy.stat_out = nxt_sy.stat.busy ? STATUS_BUSY_VAL : nxt_sy.stat;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sy_ff <= SYS_RST;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   assign o_status = sy_ff.stat_out;

endmodule : spi_eeprom_serial_front_end

// File: spi_master_model.sv
// serial master model driving the link side of the front end
module spi_master_model (
   // link outputs
   output logic sck,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   // device answer
   input wire logic so,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rxb;
   logic oe_seen;
   // clock idles low, stands still between frames
   initial {sck, cs_n, si, hold_n} = 4'h5;
   task sel();
      cs_n = 1'b0;
      #7;
   endtask : sel
   // released data line flips so a stale bit never reads as data
   task desel();
      // select hold after the last edge lets the command reach the system side
      #25 cs_n = 1'b1;
      si = ~si;
      #36;
   endtask : desel
   // msb first, hold moves with clock low
   task xfer(input logic [7:0] tx, input int n, input logic hd);
      #1 hold_n = !hd;
      oe_seen = 1'b0;
      for (int i = 0; i < n; i++) begin
         si = tx[7-i];
         #3 sck = 1'b1;
         oe_seen |= so_oe;
         rxb = {rxb[6:0], so_oe ? so : 1'bx};
         #3 sck = 1'b0;
      end
   endtask : xfer
endmodule : spi_master_model

// File: spi_eeprom_fe_props.sv
// port checks for the serial memory front end
module spi_eeprom_fe_props
   import spi_eeprom_fe_pkg::*;
#(
   parameter int WRITE_CYCLES = 20
) (
   // system side
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_wp_n,
   input wire logic [7:0] o_status,
   // link side
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic o_so,
   input wire logic o_so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   int busy_cnt_ff;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         busy_cnt_ff <= 0;
      else
         busy_cnt_ff <= o_status[0] ? busy_cnt_ff + 1 : 0;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_deselect_quiet: assert property (i_cs_n |-> !o_so_oe) else $error("so unselected");
   a_hold_quiet: assert property (!i_hold_n |-> !o_so_oe) else $error("so in pause");
   a_busy_ones: assert property (o_status[0] |-> o_status == STATUS_BUSY_VAL)
      else $error("busy byte");
   a_spare_zero: assert property (!o_status[0] |-> o_status[6:4] == 3'h0)
      else $error("spare bits");
   a_protect_pin_enable_bit_kept: assert property ($fell(o_status[7]) |-> $past(o_status[0]))
      else $error("pin enable cleared");
   a_write_len: assert property ($fell(o_status[0]) |->
      busy_cnt_ff inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]}) else $error("write length");
   a_wel_drop: assert property ($fell(o_status[0]) |-> !o_status[1])
      else $error("latch kept");
   a_wp_blocks: assert property ($rose(o_status[0]) && $past(o_status[7]) |->
      $past(i_wp_n, 6)) else $error("protected write");
   c_busy: cover property ($rose(o_status[0]));
   c_drive: cover property ($rose(o_so_oe));
   c_pause: cover property (!i_hold_n && !i_cs_n);
endmodule : spi_eeprom_fe_props
bind spi_eeprom_serial_front_end spi_eeprom_fe_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wp_n(i_wp_n), .o_status(o_status),
   .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n), .o_so(o_so),
   .o_so_oe(o_so_oe));

// File: spi_eeprom_serial_front_end_test.sv
// self-checking bench for the serial memory front end
module spi_eeprom_serial_front_end_test
   import spi_eeprom_fe_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // short write cycle keeps the run brief
   localparam int WC = 100;
   localparam logic [7:0] OP_RD = {5'h00, read_status_cmd};
   localparam logic [7:0] OP_SET = {5'h00, set_write_latch_cmd};
   localparam logic [31:0] ODD_OPS = 32'h07850302;
   logic i_clk, i_sys_rst, i_wp_n, sck, cs_n, si, hold_n, o_so, o_so_oe;
   logic [7:0] o_status;
   int failures, checks_done, cyc;
   spi_eeprom_serial_front_end #(.WRITE_CYCLES(WC)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n),
      .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status));
   spi_master_model mst (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(o_so),
      .so_oe(o_so_oe));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         conclude();
      end
   end
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task wclk(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wclk
   task frame(input logic [7:0] op, input logic [7:0] dat, input int n);
      mst.sel();
      mst.xfer(op, 8, 1'b0);
      mst.xfer(dat, n, 1'b0);
      mst.desel();
      wclk(8);
   endtask : frame
   task wr_status(input logic [7:0] dat);
      frame(OP_SET, 8'h00, 0);
      frame({5'h00, write_status_cmd}, dat, 8);
   endtask : wr_status
   task t_opcodes();
      chk("reset", STATUS_RST_VAL, o_status);
      frame(8'h0e, 8'h00, 0);
      frame(8'h0d, 8'h00, 8);
      chk("latch", 8'h02, mst.rxb);
      frame(8'h0c, 8'h00, 0);
      frame(OP_RD, 8'h00, 8);
      chk("unlatch", 8'h00, mst.rxb);
      $display("opcodes done");
   endtask : t_opcodes
   task t_write();
      wr_status(8'h8c);
      chk("busy", STATUS_BUSY_VAL, o_status);
      frame(OP_RD, 8'h00, 8);
      chk("busy so", STATUS_BUSY_VAL, mst.rxb);
      wclk(WC);
      chk("written", 8'h8c, o_status);
      $display("write done");
   endtask : t_write
   task t_protect();
      i_wp_n = 1'b0;
      wr_status(8'h00);
      chk("refused", 8'h8c, o_status & 8'h8d);
      i_wp_n = 1'b1;
      wclk(4);
      frame(OP_SET, 8'h00, 0);
      mst.sel();
      mst.xfer({5'h00, write_status_cmd}, 8, 1'b0);
      mst.xfer(8'h00, 8, 1'b0);
      wclk(1);
      i_wp_n = 1'b0;
      wclk(4);
      mst.desel();
      wclk(8);
      chk("aborted", 8'h8c, o_status & 8'h8d);
      $display("protect done");
   endtask : t_protect
   task t_started();
      i_wp_n = 1'b1;
      wclk(4);
      wr_status(8'h00);
      i_wp_n = 1'b0;
      wclk(WC);
      chk("kept", 8'h00, o_status);
      wr_status(8'h0c);
      wclk(WC);
      chk("pin off", 8'h0c, o_status);
      $display("started done");
   endtask : t_started
   task t_invalid();
      for (int i = 0; i < 4; i++) begin
         frame(ODD_OPS[8*i +: 8], OP_RD, 8);
         chk("no drive", 8'hxx, mst.rxb);
      end
      mst.sel();
      mst.xfer(8'h00, 5, 1'b0);
      mst.desel();
      frame(OP_RD, 8'h00, 8);
      chk("reframed", 8'h0c, mst.rxb);
      $display("invalid done");
   endtask : t_invalid
   task t_hold();
      mst.sel();
      mst.xfer(8'h00, 4, 1'b0);
      mst.xfer(8'hff, 6, 1'b1);
      mst.xfer(8'h50, 4, 1'b0);
      mst.xfer(8'h00, 4, 1'b0);
      mst.xfer(8'h00, 3, 1'b1);
      chk("paused oe", 8'h00, {7'h00, mst.oe_seen});
      mst.xfer(8'h00, 4, 1'b0);
      mst.xfer(8'h00, 8, 1'b0);
      mst.desel();
      chk("resumed", 8'h0c, mst.rxb);
      $display("hold done");
   endtask : t_hold
   task conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   initial begin
      i_sys_rst = 1'b1;
      i_wp_n = 1'b1;
      wclk(2);
      i_sys_rst = 1'b0;
      wclk(4);
      t_opcodes();
      t_write();
      t_protect();
      t_started();
      t_invalid();
      t_hold();
      conclude();
   end
endmodule : spi_eeprom_serial_front_end_test
